/* File: bench/ccg_clock_gen_asserts.sv */
// Concurrent checks on the ports of the clock generation top.
`timescale 1ns/1ps
module ccg_clock_gen_asserts
  import ccg_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic osc_clk_in,
  input wire logic ring_osc_in,
  input wire logic supply_good_input_in,
  input wire logic ref_clk_in,
  input wire logic ref_mode_in,
  input wire logic [DIV_W-1:0] divisor_in,
  input wire logic [DLY_W-1:0] delay_in,
  input wire logic cpu_clk_monitor_out,
  input wire logic internal_clk_out,
  input wire logic generated_system_clock_output_h_out,
  input wire logic generated_system_clock_output_l_out,
  input wire logic delayed_system_clock_output_out,
  input wire logic ring_active_out,
  input wire logic clock_lost_out,
  input wire logic locked_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  logic [7:0] still;
  // Cycles without an oscillator change; saturates so a long stop never wraps.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      still <= 8'h00;
    end else if ($changed(osc_clk_in)) begin
      still <= 8'h00;
    end else if (still != 8'hff) begin
      still <= still + 8'h01;
    end
  end
  // -------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------
  sequence s_drop;
    $fell(supply_good_input_in);
  endsequence
  sequence s_ring_soon;
    ##[1:60] ring_active_out;
  endsequence
  sequence s_mode_one;
    !ref_mode_in [*3];
  endsequence
  sequence s_mode_two;
    ref_mode_in [*3];
  endsequence
  property p_mon;
    $rose(internal_clk_out) |-> ##[0:2] cpu_clk_monitor_out;
  endproperty
  property p_no_runt;
    $changed(internal_clk_out) |=> $stable(internal_clk_out) [*2];
  endproperty
  property p_sg_drop;
    s_drop |-> s_ring_soon;
  endproperty
  property p_sg_hold;
    !supply_good_input_in && ring_active_out |=> ring_active_out;
  endproperty
  property p_lost;
    still == 8'd30 |-> clock_lost_out;
  endproperty
  property p_lost_ring;
    $rose(clock_lost_out) |-> ##[0:40] ring_active_out;
  endproperty
  property p_sg_rise;
    $rose(supply_good_input_in) && !clock_lost_out |-> ##[1:60] !ring_active_out;
  endproperty
  property p_sch_one;
    s_mode_one |-> generated_system_clock_output_h_out != generated_system_clock_output_l_out;
  endproperty
  property p_sch_two;
    s_mode_two |-> !generated_system_clock_output_h_out && generated_system_clock_output_l_out;
  endproperty
  a_mon: assert property (p_mon) else $error("monitor did not follow");
  a_no_runt: assert property (p_no_runt) else $error("short phase");
  a_sg_drop: assert property (p_sg_drop) else $error("no ring on drop");
  a_sg_hold: assert property (p_sg_hold) else $error("left ring");
  a_lost: assert property (p_lost) else $error("loss unseen");
  a_lost_ring: assert property (p_lost_ring) else $error("no ring on loss");
  a_sg_rise: assert property (p_sg_rise) else $error("no osc return");
  a_sch_one: assert property (p_sch_one) else $error("pair not apart");
  a_sch_two: assert property (p_sch_two) else $error("pair not parked");
endmodule
bind ccg_clock_gen ccg_clock_gen_asserts i_chk (.clock_in, .rst_n_in, .osc_clk_in,
  .ring_osc_in, .supply_good_input_in, .ref_clk_in, .ref_mode_in, .divisor_in, .delay_in,
  .cpu_clk_monitor_out, .internal_clk_out, .generated_system_clock_output_h_out,
  .generated_system_clock_output_l_out, .delayed_system_clock_output_out,
  .ring_active_out, .clock_lost_out, .locked_out);

/* File: bench/ccg_sys_osc.sv */
// Model of the board oscillator, ring oscillator and reference clock.
`timescale 1ns/1ps
module ccg_sys_osc #(
  parameter real OSC_HALF_NS = 20.0,
  parameter real RING_HALF_NS = 35.0,
  parameter real REF_HALF_NS = 160.0
) (
  input wire logic osc_run_in,
  output logic osc_clk_out,
  output logic ring_osc_out,
  output logic ref_clk_out
);
  // Oscillator at twice the internal rate; a stopped one freezes its level.
  initial begin
    osc_clk_out = 1'b0;
    forever begin
      #OSC_HALF_NS;
      if (osc_run_in) begin
        osc_clk_out = ~osc_clk_out;
      end
    end
  end
  // Ring and reference run free; edges fall between sampling edges.
  initial begin
    ring_osc_out = 1'b0;
    ref_clk_out = 1'b0;
    fork
      forever #RING_HALF_NS ring_osc_out = ~ring_osc_out;
      forever #REF_HALF_NS ref_clk_out = ~ref_clk_out;
    join
  end
endmodule

/* File: bench/test_cpu_clock_generation_fallback.sv */
// Self-checking bench for the clock generation block.
`timescale 1ns/1ps
module test_cpu_clock_generation_fallback;
  import ccg_pkg::*;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sg = 1'b1;
  logic osc_run = 1'b1;
  logic ref_mode = 1'b0;
  logic [DIV_W-1:0] divisor = 4'h4;
  logic [DLY_W-1:0] delay = 2'h1;
  logic osc, ring, refc, mon, intc, gh, gl, gd, ring_act, lost, lock;
  logic p_int, p_sys, p_dly, p_cpu;
  int n_fail = 0;
  int cmp_count = 0;
  int a, b;
  ccg_sys_osc i_osc (.osc_run_in(osc_run), .osc_clk_out(osc), .ring_osc_out(ring),
    .ref_clk_out(refc));
  ccg_clock_gen i_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .osc_clk_in(osc),
    .ring_osc_in(ring), .supply_good_input_in(sg), .ref_clk_in(refc),
    .ref_mode_in(ref_mode), .divisor_in(divisor), .delay_in(delay),
    .cpu_clk_monitor_out(mon), .internal_clk_out(intc),
    .generated_system_clock_output_h_out(gh), .generated_system_clock_output_l_out(gl),
    .delayed_system_clock_output_out(gd), .ring_active_out(ring_act),
    .clock_lost_out(lost), .locked_out(lock));
  // Sampling clock at 200 MHz.
  initial begin
    forever #2.5 clock_in = ~clock_in;
  end
  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Inputs move 1 ns after the edge so sampling never races them.
  task automatic step(input int n);
    repeat (n) begin
      p_int = intc;
      p_sys = gh;
      p_dly = gd;
      p_cpu = mon;
      @(posedge clock_in);
      #1;
    end
  endtask
  // High and low lengths of the internal clock, in sampling cycles.
  task automatic phase(output int hi, output int lo);
    int k;
    k = 0;
    hi = 0;
    lo = 0;
    while (!(intc && !p_int) && k < 500) begin step(1); k++; end
    while (intc === 1'b1 && hi < 500) begin step(1); hi++; end
    while (intc === 1'b0 && lo < 500) begin step(1); lo++; end
  endtask
  // Internal rises per system period, and from system rise to delayed rise.
  task automatic sys_meas(output int per, output int dly);
    int k;
    bit seen;
    k = 0;
    per = 0;
    dly = 0;
    seen = 0;
    do begin step(1); k++; end while (!(gh && !p_sys) && k < 3000);
    do begin
      step(1);
      k++;
      if (intc && !p_int) per++;
      if (gd && !p_dly && !seen && !(gh && !p_sys)) begin dly = per; seen = 1; end
    end while (!(gh && !p_sys) && k < 6000);
  endtask
  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_osc();
    int n;
    n = 0;
    phase(a, b);
    check(a, 8);
    check(b, 8);
    check(ring_act, 0);
    // The monitor toggles once per oscillator rise: ten in ten oscillator periods.
    repeat (80) begin
      step(1);
      if (mon !== p_cpu) n++;
    end
    check(n, 10);
  endtask
  task automatic t_ratio(input logic [3:0] dv, input logic [1:0] dl);
    divisor = dv;
    delay = dl;
    sys_meas(a, b);
    sys_meas(a, b);
    check(a, (dv < MIN_DIVISOR) ? MIN_DIVISOR : dv);
    check(b, dl);
    check(gl, !gh);
  endtask
  task automatic t_sg_drop();
    sg = 1'b0;
    step(60);
    check(ring_act, 1);
    phase(a, b);
    check(a, 14);
    sys_meas(a, b);
    sys_meas(a, b);
    check(a, FORCED_DIVISOR);
    check(b, FORCED_DELAY);
    sg = 1'b1;
    step(80);
    check(ring_act, 0);
    phase(a, b);
    check(b, 8);
  endtask
  // Stopping the oscillator falls back at either supply-good level.
  task automatic t_loss();
    for (int s = 0; s < 2; s++) begin
      sg = s[0];
      osc_run = 1'b0;
      step(60);
      check(lost, 1);
      check(ring_act, 1);
      osc_run = 1'b1;
      sg = 1'b1;
      step(120);
      check({lost, ring_act}, 2'b00);
    end
  endtask
  task automatic t_ref();
    int k;
    divisor = 4'h4;
    ref_mode = 1'b1;
    k = 0;
    while (lock !== 1'b1 && k < 3000) begin step(1); k++; end
    check(lock, 1);
    check({gh, gl}, 2'b01);
    ref_mode = 1'b0;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog sized well beyond the few thousand cycles the tests take.
  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end
  // Main sequence: reset for 16 cycles, then each scenario in turn.
  initial begin
    step(16);
    check({gh, gl, ring_act, lost}, 4'h7);
    rst_n_in = 1'b1;
    step(200);
    t_osc();
    t_ratio(4'h4, 2'h1);
    t_ratio(4'h3, 2'h2);
    t_ratio(4'h1, 2'h0);
    t_sg_drop();
    t_loss();
    t_ref();
    wrap_up();
  end
endmodule

/* File: core/ccg_clock_gen.sv */
// Clock generation top: oscillator divide, loss detection, ring fallback.
`timescale 1ns/1ps
module ccg_clock_gen
  import ccg_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic osc_clk_in,
  input wire logic ring_osc_in,
  input wire logic supply_good_input_in,
  input wire logic ref_clk_in,
  input wire logic ref_mode_in,
  input wire logic [DIV_W-1:0] divisor_in,
  input wire logic [DLY_W-1:0] delay_in,
  output logic cpu_clk_monitor_out,
  output logic internal_clk_out,
  output logic generated_system_clock_output_h_out,
  output logic generated_system_clock_output_l_out,
  output logic delayed_system_clock_output_out,
  output logic ring_active_out,
  output logic clock_lost_out,
  output logic locked_out
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Oscillator, ring, supply-good and reference come from outside the domain.
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic osc_prev;
  logic ring_prev;
  logic ref_prev;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {ref_clk_in, supply_good_input_in, ring_osc_in, osc_clk_in};
      sync_b <= sync_a;
    end
  end

  // Previous synchronised levels give edge detection away from the first stage.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      osc_prev <= 1'b0;
      ring_prev <= 1'b0;
      ref_prev <= 1'b0;
    end else begin
      osc_prev <= sync_b[0];
      ring_prev <= sync_b[1];
      ref_prev <= sync_b[3];
    end
  end

  logic osc_edge;
  logic ring_edge;
  logic ref_rise;
  logic supply_good;
  assign osc_edge = sync_b[0] ^ osc_prev;
  assign ring_edge = sync_b[1] ^ ring_prev;
  assign ref_rise = sync_b[3] & ~ref_prev;
  assign supply_good = sync_b[2];

  // ---------------------------------------------------------------
  // Clock-loss detector
  // ---------------------------------------------------------------
  // Any oscillator transition restarts the count; silence past the limit means loss.
  // The limit trades detection latency against false trips on slow oscillators.
  logic [CNT_W-1:0] quiet;
  logic osc_lost;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quiet <= '0;
      osc_lost <= 1'b1;
    end else if (osc_edge) begin
      quiet <= '0;
      osc_lost <= 1'b0;
    end else if (quiet == CNT_W'(LOSS_CYCLES)) begin
      osc_lost <= 1'b1;
    end else begin
      quiet <= quiet + 8'h01;
    end
  end

  // Loss forces the ring whatever supply-good says; otherwise supply-good decides.
  logic want_ring;
  assign want_ring = osc_lost | ~supply_good;

  // ---------------------------------------------------------------
  // Source selection
  // ---------------------------------------------------------------
  // Switching waits for the internal clock low phase so no phase is cut short.
  ccg_src_e state;
  ccg_src_e next_state;
  logic int_clk;

  always_comb begin
    next_state = state;
    case (state)
      CCG_SRC_OSC: begin
        if (want_ring) begin
          next_state = CCG_SRC_WAIT_RING;
        end
      end
      CCG_SRC_WAIT_RING: begin
        if (!want_ring) begin
          next_state = CCG_SRC_OSC;
        end else if (!int_clk) begin
          next_state = CCG_SRC_RING;
        end
      end
      CCG_SRC_RING: begin
        if (!want_ring) begin
          next_state = CCG_SRC_WAIT_OSC;
        end
      end
      CCG_SRC_WAIT_OSC: begin
        if (want_ring) begin
          next_state = CCG_SRC_RING;
        end else if (!int_clk) begin
          next_state = CCG_SRC_OSC;
        end
      end
      default: begin
        next_state = CCG_SRC_RING;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= CCG_SRC_RING;
    end else begin
      state <= next_state;
    end
  end

  logic use_ring;
  assign use_ring = (state == CCG_SRC_RING) || (state == CCG_SRC_WAIT_OSC);

  // ---------------------------------------------------------------
  // Divide by two
  // ---------------------------------------------------------------
  // Each rising edge of the chosen source toggles the internal clock: two source
  // periods form one internal period, so duty is exactly 50%.
  // Toggling holds during a pending switch only in its low phase.
  // A dead oscillator can never end a high phase, so a pending move to the
  // ring takes its edges from the ring once loss has been declared.
  logic src_edge;
  logic hold_low;
  logic int_tick;
  logic src_rise;
  logic ring_src;
  logic may_toggle;
  logic [1:0] run;
  assign ring_src = use_ring || ((state == CCG_SRC_WAIT_RING) && osc_lost);
  assign src_edge = ring_src ? ring_edge : osc_edge;
  assign src_rise = src_edge & (ring_src ? sync_b[1] : sync_b[0]);
  assign hold_low = ((state == CCG_SRC_WAIT_RING) || (state == CCG_SRC_WAIT_OSC)) & ~int_clk;
  assign may_toggle = src_rise & ~hold_low & (run == MIN_PHASE);
  assign int_tick = may_toggle & int_clk;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      int_clk <= 1'b0;
    end else if (may_toggle) begin
      int_clk <= ~int_clk;
    end
  end

  // Cycles since the last toggle, saturating. An edge that comes too soon after
  // a source switch is skipped, which stretches that phase instead of cutting it.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run <= '0;
    end else if (may_toggle) begin
      run <= '0;
    end else if (run != MIN_PHASE) begin
      run <= run + 2'h1;
    end
  end

  // The monitor output follows the source transitions after the internal toggle.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cpu_clk_monitor_out <= 1'b0;
      internal_clk_out <= 1'b0;
    end else begin
      cpu_clk_monitor_out <= int_clk;
      internal_clk_out <= int_clk;
    end
  end

  // ---------------------------------------------------------------
  // System clock settings and generator
  // ---------------------------------------------------------------
  // On supply-good fallback the divisor and delay are forced; a divisor
  // below the minimum is clamped since the divider cannot make it.
  ccg_cfg_s cfg;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg <= '{divisor: RESET_DIVISOR, delay: RESET_DELAY};
    end else if (!supply_good) begin
      cfg <= '{divisor: FORCED_DIVISOR, delay: FORCED_DELAY};
    end else begin
      cfg.divisor <= (divisor_in < MIN_DIVISOR) ? MIN_DIVISOR : divisor_in;
      cfg.delay <= delay_in;
    end
  end

  logic sys_clk;
  logic sys_dly;
  logic sys_lock;
  ccg_sys_clk u_sys_clk (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .int_tick_in(int_tick),
    .cfg_in(cfg),
    .ref_mode_in(ref_mode_in),
    .ref_rise_in(ref_rise),
    .sys_clk_out(sys_clk),
    .sys_clk_dly_out(sys_dly),
    .locked_out(sys_lock)
  );

  // Registered outputs; the pair is differential in scheme one, quiet in scheme two.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      generated_system_clock_output_h_out <= 1'b0;
      generated_system_clock_output_l_out <= 1'b1;
      delayed_system_clock_output_out <= 1'b0;
      locked_out <= 1'b0;
      ring_active_out <= 1'b1;
      clock_lost_out <= 1'b1;
    end else begin
      generated_system_clock_output_h_out <= ~ref_mode_in & sys_clk;
      generated_system_clock_output_l_out <= ref_mode_in | ~sys_clk;
      delayed_system_clock_output_out <= sys_dly;
      locked_out <= sys_lock;
      ring_active_out <= use_ring;
      clock_lost_out <= osc_lost;
    end
  end

endmodule

/* File: core/ccg_sys_clk.sv */
// System clock generator: ratio divider, delayed copy and reference lock.
`timescale 1ns/1ps
module ccg_sys_clk
  import ccg_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic int_tick_in,
  input wire ccg_cfg_s cfg_in,
  input wire logic ref_mode_in,
  input wire logic ref_rise_in,
  output logic sys_clk_out,
  output logic sys_clk_dly_out,
  output logic locked_out
);

  logic [DIV_W-1:0] phase;
  logic [1:0] hist;
  logic [CNT_W-1:0] err;
  logic next_sys;
  logic [3:0] taps;

  // ---------------------------------------------------------------
  // Ratio divider
  // ---------------------------------------------------------------
  // Phase advances on each internal clock tick; a reference edge realigns it.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase <= '0;
    end else if (ref_mode_in && ref_rise_in) begin
      phase <= '0;
    end else if (int_tick_in) begin
      if (phase >= cfg_in.divisor - 4'h1) begin
        phase <= '0;
      end else begin
        phase <= phase + 4'h1;
      end
    end
  end

  // High for the first half of each ratio period, synchronous to the ticks.
  // The taps line up the coming level and the levels of the last three ticks.
  assign next_sys = (phase < (cfg_in.divisor >> 1));
  assign taps = {hist, sys_clk_out, next_sys};

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sys_clk_out <= 1'b0;
      hist <= '0;
    end else if (int_tick_in) begin
      sys_clk_out <= next_sys;
      hist <= {hist[0], sys_clk_out};
    end
  end

  // Delayed copy taken delay ticks after the main system clock.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sys_clk_dly_out <= 1'b0;
    end else if (int_tick_in) begin
      sys_clk_dly_out <= taps[cfg_in.delay];
    end
  end

  // ---------------------------------------------------------------
  // Lock detection
  // ---------------------------------------------------------------
  // Lock is declared once reference edges land on phase zero or the last phase repeatedly.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      err <= '0;
      locked_out <= 1'b0;
    end else if (!ref_mode_in) begin
      err <= '0;
      locked_out <= 1'b0;
    end else if (ref_rise_in) begin
      if (phase == '0 || phase == cfg_in.divisor - 4'h1) begin
        if (err != LOCK_WINDOW) begin
          err <= err + 8'h01;
        end
        locked_out <= (err == LOCK_WINDOW);
      end else begin
        err <= '0;
        locked_out <= 1'b0;
      end
    end
  end

endmodule

/* File: pkg/ccg_pkg.sv */
// Package of constants and carrier types for the clock generation block.
// Contract
// - The oscillator input is divided by two to give a 50% duty internal clock.
// - The CPU clock monitor output toggles following the oscillator transitions.
// - Scheme one drives a differential system clock synchronous to the internal clock.
// - Scheme two locks the internal clock to a system reference through a digital PLL; the code only realigns the ratio divider phase on reference rises.
// - The oscillator is the time base only while supply-good is asserted.
// - With supply-good deasserted the device runs from the ring oscillator.
// - On ring fallback from supply-good the divisor is forced to 8 and the delay to 3.
// - From the ring oscillator the internal clock is half the ring frequency.
// - Detecting an absent oscillator switches the source to the ring oscillator.
// - The clock-loss fallback happens whatever the supply-good level.
// - With the oscillator present supply-good selects the source normally.
package ccg_pkg;

  // ---------------------------------------------------------------
  // Timing and field constants
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned LOSS_TIME_NS = 100;
  localparam int unsigned LOSS_CYCLES = (LOSS_TIME_NS * CLK_MHZ) / 1000;
  localparam int CNT_W = 8;
  localparam int DIV_W = 4;
  localparam int DLY_W = 2;
  localparam logic [DIV_W-1:0] FORCED_DIVISOR = 4'h8;
  localparam logic [DLY_W-1:0] FORCED_DELAY = 2'h3;
  localparam logic [DIV_W-1:0] RESET_DIVISOR = 4'h2;
  localparam logic [DLY_W-1:0] RESET_DELAY = 2'h0;
  localparam logic [DIV_W-1:0] MIN_DIVISOR = 4'h2;
  localparam logic [CNT_W-1:0] LOCK_WINDOW = 8'h02;
  // Cycles the internal clock must rest after a toggle before it may toggle again.
  localparam logic [1:0] MIN_PHASE = 2'h2;

  // Source selector states, Gray along the usual path.
  typedef enum logic [1:0] {
    CCG_SRC_OSC = 2'b00,
    CCG_SRC_WAIT_RING = 2'b01,
    CCG_SRC_RING = 2'b11,
    CCG_SRC_WAIT_OSC = 2'b10
  } ccg_src_e;

  // Settings actually applied to the system clock generator.
  typedef struct packed {
    logic [DIV_W-1:0] divisor;
    logic [DLY_W-1:0] delay;
  } ccg_cfg_s;

endpackage
